// File: rtl/jtscan_tap.sv
`include "jtscan_map.svh"
`default_nettype none
module jtscan_tap #(
  // arbitrary identity values
  parameter logic [`JTSCAN_ID_MAKER_W-1:0] MAKER_CODE = 11'h055,
  parameter logic [`JTSCAN_ID_PART_W-1:0] PART_CODE = 16'h1234,
  parameter logic [`JTSCAN_ID_VER_W-1:0] VERSION = 4'h1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // test port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // boundary side
  input wire logic [`JTSCAN_CHAIN_LEN-1:0] pin_obs_i,
  output logic [`JTSCAN_CHAIN_LEN-1:0] pin_drive_o,
  output logic test_mode_o,
  // status
  output logic [`JTSCAN_IR_W-1:0] instr_o
);

  // pin synchronisers
  logic [1:0] tck_s;
  logic [1:0] tms_s;
  logic [1:0] tdi_s;
  logic tck_d;
  // bits sync independently; the pins are unrelated levels
  logic [`JTSCAN_CHAIN_LEN-1:0] obs_s0;
  logic [`JTSCAN_CHAIN_LEN-1:0] obs_s1;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tck_s <= 2'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h0;
      tck_d <= 1'b0;
    end else begin
      tck_s <= {tck_s[0], tck_i};
      tms_s <= {tms_s[0], tms_i};
      tdi_s <= {tdi_s[0], tdi_i};
      tck_d <= tck_s[1];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      obs_s0 <= '0;
      obs_s1 <= '0;
    end else begin
      obs_s0 <= pin_obs_i;
      obs_s1 <= obs_s0;
    end
  end

  wire tck_rise = tck_s[1] & ~tck_d;
  wire tck_fall = ~tck_s[1] & tck_d;
  wire tms = tms_s[1];
  wire tdi = tdi_s[1];

  jtscan_pkg::jtscan_state_t state;
  jtscan_pkg::jtscan_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      jtscan_pkg::ST_RESET: begin
        if (!tms) begin
          next_state = jtscan_pkg::ST_IDLE; // [R8]
        end
      end
      jtscan_pkg::ST_IDLE: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_SEL_DR; // [R9]
        end
      end
      jtscan_pkg::ST_SEL_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_SEL_IR; // [R10]
        end else begin
          next_state = jtscan_pkg::ST_CAP_DR; // [R10]
        end
      end
      jtscan_pkg::ST_CAP_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT1_DR; // [R11]
        end else begin
          next_state = jtscan_pkg::ST_SHIFT_DR; // [R11]
        end
      end
      jtscan_pkg::ST_SHIFT_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT1_DR; // [R12]
        end
      end
      jtscan_pkg::ST_EXIT1_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_UPD_DR; // [R13]
        end else begin
          next_state = jtscan_pkg::ST_PAUSE_DR; // [R13]
        end
      end
      jtscan_pkg::ST_PAUSE_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT2_DR; // [R14]
        end
      end
      jtscan_pkg::ST_EXIT2_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_UPD_DR; // [R15]
        end else begin
          next_state = jtscan_pkg::ST_SHIFT_DR; // [R15]
        end
      end
      jtscan_pkg::ST_UPD_DR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_SEL_DR;
        end else begin
          next_state = jtscan_pkg::ST_IDLE;
        end
      end
      jtscan_pkg::ST_SEL_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_RESET; // [R17]
        end else begin
          next_state = jtscan_pkg::ST_CAP_IR; // [R17]
        end
      end
      jtscan_pkg::ST_CAP_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT1_IR; // [R18]
        end else begin
          next_state = jtscan_pkg::ST_SHIFT_IR; // [R18]
        end
      end
      jtscan_pkg::ST_SHIFT_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT1_IR; // [R19]
        end
      end
      jtscan_pkg::ST_EXIT1_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_UPD_IR; // [R20]
        end else begin
          next_state = jtscan_pkg::ST_PAUSE_IR; // [R20]
        end
      end
      jtscan_pkg::ST_PAUSE_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_EXIT2_IR; // [R23]
        end
      end
      jtscan_pkg::ST_EXIT2_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_UPD_IR; // [R23]
        end else begin
          next_state = jtscan_pkg::ST_SHIFT_IR; // [R23]
        end
      end
      jtscan_pkg::ST_UPD_IR: begin
        if (tms) begin
          next_state = jtscan_pkg::ST_SEL_DR;
        end else begin
          next_state = jtscan_pkg::ST_IDLE;
        end
      end
      default: next_state = jtscan_pkg::ST_RESET;
    endcase
  end

  // one step per sampled TCK rise
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= jtscan_pkg::ST_RESET;
    end else if (tck_rise) begin
      state <= next_state; // [R6]
    end
  end

  // data register choice from the current instruction
  function automatic jtscan_pkg::jtscan_sel_t dr_select(input logic [`JTSCAN_IR_W-1:0] code);
    if (code == `JTSCAN_IR_EXTEST || code == `JTSCAN_IR_SAMPLE) begin
      dr_select = jtscan_pkg::SEL_CHAIN;
    end else if (code == `JTSCAN_IR_IDCODE) begin
      dr_select = jtscan_pkg::SEL_IDENT;
    end else begin
      // bypass, clamp and unknown codes all take the short path
      dr_select = jtscan_pkg::SEL_PASS;
    end
  endfunction : dr_select

  logic [`JTSCAN_IR_W-1:0] ir_stage;
  logic [`JTSCAN_IR_W-1:0] ir_cur;

  wire jtscan_pkg::jtscan_sel_t sel = dr_select(ir_cur);
  wire in_cap_dr = (state == jtscan_pkg::ST_CAP_DR);
  wire in_shift_dr = (state == jtscan_pkg::ST_SHIFT_DR);
  wire in_shift_ir = (state == jtscan_pkg::ST_SHIFT_IR);
  wire chain_cap = tck_rise & in_cap_dr & (sel == jtscan_pkg::SEL_CHAIN);
  wire chain_shift = tck_rise & in_shift_dr & (sel == jtscan_pkg::SEL_CHAIN);
  wire chain_upd = tck_fall & (state == jtscan_pkg::ST_UPD_DR) & (sel == jtscan_pkg::SEL_CHAIN);
  wire clamp_or_ext = (ir_cur == `JTSCAN_IR_EXTEST) || (ir_cur == `JTSCAN_IR_CLAMP);

  wire in_reset = (state == jtscan_pkg::ST_RESET);
  wire ir_cap = tck_rise & (state == jtscan_pkg::ST_CAP_IR);
  wire ir_shift = tck_rise & in_shift_ir;
  wire ir_upd = tck_fall & (state == jtscan_pkg::ST_UPD_IR);

  // instruction shift stages
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ir_stage <= `JTSCAN_IR_CAPTURE;
    end else if (ir_cap) begin
      ir_stage <= `JTSCAN_IR_CAPTURE; // [R18]
    end else if (ir_shift) begin
      ir_stage <= {tdi, ir_stage[`JTSCAN_IR_W-1:1]}; // [R19] [R21]
    end
  end

  // current instruction; the reset state wins over any update
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ir_cur <= `JTSCAN_IR_IDCODE;
    end else if (in_reset) begin
      ir_cur <= `JTSCAN_IR_IDCODE; // [R7]
    end else if (ir_upd) begin
      ir_cur <= ir_stage; // [R24]
    end
  end

  // ident and pass registers
  logic [`JTSCAN_ID_W-1:0] ident;
  logic pass_bit;
  wire [`JTSCAN_ID_W-1:0] ident_value = {VERSION, PART_CODE, MAKER_CODE, 1'b1}; // [R1]
  wire id_cap = tck_rise & in_cap_dr & (sel == jtscan_pkg::SEL_IDENT);
  wire id_shift = tck_rise & in_shift_dr & (sel == jtscan_pkg::SEL_IDENT);
  wire pass_cap = tck_rise & in_cap_dr & (sel == jtscan_pkg::SEL_PASS);
  wire pass_shift = tck_rise & in_shift_dr & (sel == jtscan_pkg::SEL_PASS);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ident <= ident_value;
    end else if (id_cap) begin
      ident <= ident_value;
    end else if (id_shift) begin
      ident <= {tdi, ident[`JTSCAN_ID_W-1:1]}; // [R22]
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pass_bit <= 1'b0;
    end else if (pass_cap) begin
      pass_bit <= 1'b0;
    end else if (pass_shift) begin
      pass_bit <= tdi; // [R2]
    end
  end

  logic chain_out;
  logic [`JTSCAN_CHAIN_LEN-1:0] chain_latch;

  jtscan_chain u_chain (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .capture_i(chain_cap),
    .shift_i(chain_shift),
    .update_i(chain_upd),
    .tdi_i(tdi),
    .par_i(obs_s1),
    .latch_o(chain_latch),
    .sout_o(chain_out)
  ); // [R5]

  wire dr_out = (sel == jtscan_pkg::SEL_CHAIN) ? chain_out :
                (sel == jtscan_pkg::SEL_IDENT) ? ident[0] : pass_bit;
  wire next_tdo = in_shift_ir ? ir_stage[0] : dr_out;
  wire next_tdo_oe = in_shift_ir | in_shift_dr;

  // tdo moves on the fall so the tester can sample on the next rise
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= next_tdo; // [R25]
      tdo_oe_o <= next_tdo_oe; // [R25]
    end
  end

  // drive side: test mode only under extest or clamp, never in reset state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_drive_o <= '0;
      test_mode_o <= 1'b0;
      instr_o <= `JTSCAN_IR_IDCODE;
    end else begin
      pin_drive_o <= chain_latch; // [R4]
      test_mode_o <= clamp_or_ext && state != jtscan_pkg::ST_RESET; // [R7]
      instr_o <= ir_cur;
    end
  end

endmodule : jtscan_tap
`default_nettype wire

// File: shared/jtscan_map.svh
// Notes on behaviour
// [R1] 32-bit ident word: bit0 one, maker 1-11, part 12-27, version 28-31.
// [R2] one-stage pass register is the shortest serial path when selected.
// [R3] input cells only observe their pin and never drive it.
// [R4] output cells capture and drive their pin from the latched value.
// [R5] pin chain holds cells 1 to 77 with fixed input/output types.
// [R6] controller is a 16-state machine stepped by TMS on TCK rise.
// [R7] reset state disables test logic and loads the ident instruction.
// [R8] five TCK rises with TMS high reach reset state from anywhere.
// [R9] idle holds while TMS low, goes to select-DR on TMS high.
// [R10] select-DR goes to capture-DR on low, select-IR on high.
// [R11] capture-DR loads pin chain under extest or sample only.
// [R12] shift-DR moves selected register one stage toward TDO per rise.
// [R13] exit1-DR goes to update-DR on high, pause-DR on low.
// [R14] pause-DR holds contents while TMS low, exit2-DR on high.
// [R15] exit2-DR goes to update-DR on high, back to shift-DR on low.
// [R16] update-DR copies chain into latches on TCK fall, nowhere else.
// [R17] select-IR goes to capture-IR on low, reset state on high.
// [R18] capture-IR loads pattern 100 into instruction stages.
// [R19] shift-IR moves instruction stages toward TDO per rise.
// [R20] exit1-IR goes to update-IR on high, pause-IR on low.
// [R21] 3-bit instruction, LSB first; 000,001,010,011,111 codes.
// [R22] ident word leaves on TDO least significant bit first.
// [R23] pause-IR holds on low; exit2-IR to update-IR or shift-IR.
// [R24] update-IR latches new instruction on TCK fall.
// [R25] TDO changes on TCK fall and is driven only while shifting.
`ifndef JTSCAN_MAP_SVH
`define JTSCAN_MAP_SVH

`define JTSCAN_IR_W 3
`define JTSCAN_IR_EXTEST 3'h0
`define JTSCAN_IR_IDCODE 3'h1
`define JTSCAN_IR_SAMPLE 3'h2
`define JTSCAN_IR_CLAMP 3'h3
`define JTSCAN_IR_BYPASS 3'h7
`define JTSCAN_IR_CAPTURE 3'h4

`define JTSCAN_ID_W 32
`define JTSCAN_ID_FIXED_BIT 0
`define JTSCAN_ID_MAKER_LSB 1
`define JTSCAN_ID_MAKER_W 11
`define JTSCAN_ID_PART_LSB 12
`define JTSCAN_ID_PART_W 16
`define JTSCAN_ID_VER_LSB 28
`define JTSCAN_ID_VER_W 4

`define JTSCAN_CHAIN_LEN 77
// bit n-1 set where cell n is an output cell
`define JTSCAN_OUT_CELLS 77'h12555546008b7b16f606

`endif

// File: shared/jtscan_pkg.sv
`default_nettype none
package jtscan_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } jtscan_state_t;

  typedef enum logic [1:0] {
    SEL_PASS,
    SEL_IDENT,
    SEL_CHAIN
  } jtscan_sel_t;

endpackage : jtscan_pkg
`default_nettype wire

// File: rtl/jtscan_chain.sv
`include "jtscan_map.svh"
`default_nettype none
module jtscan_chain (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // strobes from the controller, one cycle each
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic tdi_i,
  // parallel side
  input wire logic [`JTSCAN_CHAIN_LEN-1:0] par_i,
  output logic [`JTSCAN_CHAIN_LEN-1:0] latch_o,
  output logic sout_o
);

  localparam logic [`JTSCAN_CHAIN_LEN-1:0] OUT_MASK = `JTSCAN_OUT_CELLS;

  logic [`JTSCAN_CHAIN_LEN-1:0] stage;
  logic [`JTSCAN_CHAIN_LEN:0] ser;

  assign ser[`JTSCAN_CHAIN_LEN] = tdi_i;
  assign sout_o = ser[0];

  genvar n;
  generate
    for (n = 0; n < `JTSCAN_CHAIN_LEN; n = n + 1) begin : g_cell
      assign ser[n] = stage[n];
      // every cell observes its pin or system value
      always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
          stage[n] <= 1'b0;
        end else if (capture_i) begin
          stage[n] <= par_i[n]; // [R3] [R4] [R11]
        end else if (shift_i) begin
          stage[n] <= ser[n+1]; // [R12]
        end
      end
      if (OUT_MASK[n]) begin : g_out
        always_ff @(posedge clock_i) begin
          if (sys_rst_i) begin
            latch_o[n] <= 1'b0;
          end else if (update_i) begin
            latch_o[n] <= stage[n]; // [R4] [R16]
          end
        end
      end else begin : g_in
        // input cells have no latch and so cannot drive
        assign latch_o[n] = 1'b0; // [R3]
      end
    end
  endgenerate

endmodule : jtscan_chain
`default_nettype wire

// File: testbench/jtscan_tap_sva.sv
`include "jtscan_map.svh"
`default_nettype none
module jtscan_tap_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // test port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  // boundary and status
  input wire logic [`JTSCAN_CHAIN_LEN-1:0] pin_drive_o,
  input wire logic test_mode_o,
  input wire logic [`JTSCAN_IR_W-1:0] instr_o
);
  logic tck_d;
  logic [2:0] hi_cnt;
  // raw pin count, saturating so a long high run never wraps
  always_ff @(posedge clock_i) begin
    tck_d <= tck_i;
    if (sys_rst_i) hi_cnt <= 3'h0;
    else if (tck_i && !tck_d) hi_cnt <= tms_i ? hi_cnt + {2'h0, hi_cnt != 3'h7} : 3'h0;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_values: assert property ($fell(sys_rst_i) |-> instr_o == 3'h1 && !tdo_oe_o && !test_mode_o)
    else $error("outputs wrong after reset");
  a_input_cells: assert property ((pin_drive_o & ~`JTSCAN_OUT_CELLS) == '0)
    else $error("input cell drives its pin");
  a_drive_hold: assert property ($changed(pin_drive_o) |-> !tdo_oe_o)
    else $error("pin latch changed while shifting");
  a_instr_hold: assert property ($changed(instr_o) |-> !tdo_oe_o)
    else $error("instruction changed while shifting");
  // pin fall sampled three edges before the output moves: two sync stages and the edge detect
  a_tdo_on_fall: assert property (!$past(sys_rst_i) && $changed(tdo_o) |-> $past(tck_i, 4) && !$past(tck_i, 3))
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property (!$past(sys_rst_i) && $changed(tdo_oe_o) |-> $past(tck_i, 4) && !$past(tck_i, 3))
    else $error("tdo enable moved away from a tck fall");
  a_mode_instr: assert property (test_mode_o |-> instr_o inside {3'h0, 3'h3} || $past(instr_o) inside {3'h0, 3'h3})
    else $error("test mode without extest or clamp");
  a_tms_reset: assert property (tck_i && !tck_d && tms_i && hi_cnt == 3'h4 |-> ##[1:10] instr_o == 3'h1 && !test_mode_o)
    else $error("five high tms rises did not reset");
endmodule : jtscan_tap_sva
`default_nettype wire

// File: testbench/jtscan_host.sv
`default_nettype none
module jtscan_host (
  // system clock paces the tester
  input wire logic clock_i,
  // from the device
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // to the device
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // tck stays low between steps; tdo taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic [1:0] seen);
    tms_o = tms;
    tdi_o = tdi;
    repeat (4) @(negedge clock_i);
    seen = {tdo_oe_i, tdo_i};
    tck_o = 1'b1;
    repeat (4) @(negedge clock_i);
    tck_o = 1'b0;
  endtask : step
  task automatic tap_reset;
    logic [1:0] s;
    repeat (5) step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  endtask : tap_reset
  // idle to idle; p picks a shift bit after which the scan pauses
  task automatic scan(input logic ir, input int n, input int p, input logic [76:0] din,
                      output logic [76:0] dout, output logic oe_ok);
    logic [1:0] s;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b0, s);
    if (ir) step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
    step(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i], s);
      dout[i] = s[0];
      oe_ok &= s[1];
      if (i == p && i != n - 1) begin
        step(1'b0, 1'b0, s);
        step(1'b0, 1'b0, s);
        oe_ok &= !s[1];
        step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
      end
    end
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  endtask : scan
endmodule : jtscan_host
`default_nettype wire

// File: testbench/jtscan_tap_tb_top.sv
`include "jtscan_map.svh"
`default_nettype none
module jtscan_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary identity values
  localparam logic [10:0] MK = 11'h2a3;
  localparam logic [15:0] PT = 16'h5c71;
  localparam logic [3:0] VR = 4'h6;
  localparam logic [76:0] OUTS = `JTSCAN_OUT_CELLS;
  localparam logic [76:0] P = 77'h1_2345_6789_abcd_ef01_234;
  localparam logic [76:0] D = 77'h0_ffff_0000_ff00_f0f0_cc3;
  logic clock_i, sys_rst_i, tck, tms, tdi, tdo, tdo_oe, test_mode, oe_ok;
  logic [2:0] instr;
  logic [76:0] pin_obs, pin_drive, dout;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  jtscan_tap #(.MAKER_CODE(MK), .PART_CODE(PT), .VERSION(VR)) i_jtscan_tap (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .pin_obs_i(pin_obs), .pin_drive_o(pin_drive), .test_mode_o(test_mode), .instr_o(instr));
  jtscan_host i_jtscan_host (.clock_i(clock_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));
  task automatic check(input string what, input logic [76:0] exp, input logic [76:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic load_ir(input logic [2:0] code);
    i_jtscan_host.scan(1'b1, 3, 1, 77'(code), dout, oe_ok);
    check("ir capture", 77'h4, dout);
    check("instr", 77'(code), 77'(instr));
    check("test mode", 77'(code == 3'h0 || code == 3'h3), 77'(test_mode));
  endtask : load_ir
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    pin_obs = P;
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    check("reset instr", 77'h1, 77'(instr));
    i_jtscan_host.tap_reset();
    i_jtscan_host.scan(1'b0, 32, 99, 77'h0, dout, oe_ok);
    check("ident", 77'({VR, PT, MK, 1'b1}), dout);
    check("oe shift", 77'h1, 77'(oe_ok));
    $display("test ident done");
    load_ir(3'h7);
    i_jtscan_host.scan(1'b0, 8, 99, 77'hb5, dout, oe_ok);
    check("pass bit", 77'h6a, dout);
    $display("test bypass done");
    load_ir(3'h2);
    i_jtscan_host.scan(1'b0, 77, 40, D, dout, oe_ok);
    check("sample", P, dout);
    check("preload", D & OUTS, pin_drive);
    $display("test sample done");
    load_ir(3'h0);
    pin_obs = ~P;
    i_jtscan_host.scan(1'b0, 77, 99, ~D, dout, oe_ok);
    check("extest", ~P, dout);
    check("extest drive", ~D & OUTS, pin_drive);
    load_ir(3'h3);
    i_jtscan_host.scan(1'b0, 4, 99, 77'h9, dout, oe_ok);
    check("clamp path", 77'h2, dout);
    check("clamp drive", ~D & OUTS, pin_drive);
    $display("test extest clamp done");
    i_jtscan_host.tap_reset();
    check("tms reset", 77'h1, 77'(instr));
    check("mode off", 77'h0, 77'(test_mode));
    $display("test tms reset done");
    end_sim();
  end
endmodule : jtscan_tap_tb_top
bind jtscan_tap jtscan_tap_sva i_jtscan_tap_sva (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_drive_o(pin_drive_o), .test_mode_o(test_mode_o),
  .instr_o(instr_o));
`default_nettype wire
